// ---- inc/np_regs_pkg.sv ----
// Register map, field positions and reset values for the next page
// transmit word, the summary status word and the pair swap control word.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
package np_regs_pkg;

   // ------------------------------------------------------------
   // Register indices and byte addresses
   // ------------------------------------------------------------
   localparam int         ADDR_W        = 8;
   localparam logic [7:0] NPTX_IDX      = 8'h07;
   localparam logic [7:0] STATUS_IDX    = 8'h10;
   localparam logic [7:0] CONTROL_IDX   = 8'h19;
   localparam logic [7:0] NPTX_ADDR     = {NPTX_IDX[5:0], 2'b00};
   localparam logic [7:0] STATUS_ADDR   = {STATUS_IDX[5:0], 2'b00};
   localparam logic [7:0] CONTROL_ADDR  = {CONTROL_IDX[5:0], 2'b00};

   // ------------------------------------------------------------
   // Next page transmit word fields
   // ------------------------------------------------------------
   localparam int          MORE_BIT     = 15;
   localparam int          NP_RSVD_BIT  = 14;
   localparam int          MSG_BIT      = 13;
   localparam int          ACK_BIT      = 12;
   localparam int          TOG_BIT      = 11;
   localparam int          CODE_W       = 11;
   localparam logic        MORE_RST     = 1'h0;
   localparam logic        MSG_RST      = 1'h1;
   localparam logic        ACK_RST      = 1'h0;
   localparam logic        TOG_RST      = 1'h0;
   localparam logic [10:0] CODE_RST     = 11'h001;

   // ------------------------------------------------------------
   // Status and control word fields
   // ------------------------------------------------------------
   localparam int          ST_RSVD_BIT  = 15;
   localparam int          SWAP_BIT     = 14;
   localparam int          AUTO_EN_BIT  = 15;
   localparam int          FORCE_BIT    = 14;
   localparam logic        AUTO_EN_RST  = 1'h1;
   localparam logic        FORCE_RST    = 1'h0;

   // ------------------------------------------------------------
   // Bus answers and crossover modes
   // ------------------------------------------------------------
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_FORCED = 2'b01,
      MODE_AUTO   = 2'b10
   } swap_mode_e;

endpackage

// ---- inc/swap_if.sv ----
// Carrier between the register block and the pair swap tracker.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface swap_if;
   logic auto_crossover_enable;
   logic crossover_force;
   logic algo_swap;
   logic pair_swap_state;

   modport regs
   (
      output auto_crossover_enable,
      output crossover_force,
      output algo_swap,
      input  pair_swap_state
   );

   modport tracker
   (
      input  auto_crossover_enable,
      input  crossover_force,
      input  algo_swap,
      output pair_swap_state
   );
endinterface

// ---- hdl/crossover_tracker.sv ----
// Pair swap state tracker behind the summary status word.
// Assumes an active-low reset whose release is already synchronised.
`timescale 1ns/1ps
module crossover_tracker
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // Control and state
   swap_if.tracker   sw
);
   np_regs_pkg::swap_mode_e mode_r;
   logic                    swap_r;

   // ------------------------------------------------------------
   // Mode selection
   // ------------------------------------------------------------
   // enable and force
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         mode_r <= np_regs_pkg::MODE_NORMAL;
      else if (sw.crossover_force)
         mode_r <= np_regs_pkg::MODE_FORCED;
      else if (sw.auto_crossover_enable)
         mode_r <= np_regs_pkg::MODE_AUTO;
      else
         mode_r <= np_regs_pkg::MODE_NORMAL;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         swap_r <= 1'h0;
      else
         case (mode_r)
            np_regs_pkg::MODE_FORCED: swap_r <= 1'h1;
            np_regs_pkg::MODE_AUTO:   swap_r <= sw.algo_swap;
            default:                  swap_r <= 1'h0;
         endcase
   end

   assign sw.pair_swap_state = swap_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_swap_tracks_algo: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (sw.auto_crossover_enable && !sw.crossover_force)[*2] |=> swap_r == $past(sw.algo_swap))
      else $error("swap state does not follow the algorithm");
   chk_swap_forced: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      sw.crossover_force[*2] |=> swap_r)
      else $error("forced crossover not shown as swapped");
endmodule

// ---- hdl/next_page_regs.sv ----
// Next page transmit word and summary status word behind AXI4-Lite.
// Assumes the negotiation engine pulses page_exchanged_in per exchange.
`timescale 1ns/1ps
module next_page_regs
#(
   parameter int ADDR_W = np_regs_pkg::ADDR_W
)
(
   // Clock and reset
   input  wire logic              clock_in,
   input  wire logic              reset_n_in,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W-1:0] axi_awaddr_in,
   input  wire logic              axi_awvalid_in,
   output logic                   axi_awready_out,
   input  wire logic [31:0]       axi_wdata_in,
   input  wire logic [3:0]        axi_wstrb_in,
   input  wire logic              axi_wvalid_in,
   output logic                   axi_wready_out,
   // AXI4-Lite write response
   output logic [1:0]             axi_bresp_out,
   output logic                   axi_bvalid_out,
   input  wire logic              axi_bready_in,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] axi_araddr_in,
   input  wire logic              axi_arvalid_in,
   output logic                   axi_arready_out,
   output logic [31:0]            axi_rdata_out,
   output logic [1:0]             axi_rresp_out,
   output logic                   axi_rvalid_out,
   input  wire logic              axi_rready_in,
   // Negotiation engine
   input  wire logic              an_in_progress_in,
   input  wire logic              page_exchanged_in,
   input  wire logic              exchanged_toggle_in,
   output logic [15:0]            next_page_out,
   output logic                   next_page_valid_out,
   // Crossover algorithm
   input  wire logic              pair_swap_algo_in,
   output logic                   pair_swap_state_out
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rst_meta_r <= 1'h0;
         rst_n_r    <= 1'h0;
      end
      else
      begin
         rst_meta_r <= 1'h1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Byte lane merge for the low half word; upper lanes hold no bits
   function automatic logic [15:0] merge16
   (
      input logic [15:0] old_v,
      input logic [15:0] new_v,
      input logic [1:0]  strb
   );
      logic [15:0] res;
      res       = old_v;
      if (strb[0])
         res[7:0] = new_v[7:0];
      if (strb[1])
         res[15:8] = new_v[15:8];
      return res;
   endfunction

   function automatic logic is_mapped
   (
      input logic [ADDR_W-1:0] addr
   );
      return (addr == ADDR_W'(np_regs_pkg::NPTX_ADDR))
          || (addr == ADDR_W'(np_regs_pkg::STATUS_ADDR))
          || (addr == ADDR_W'(np_regs_pkg::CONTROL_ADDR));
   endfunction

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic                    more_pages_wanted_r;
   logic                    message_page_flag_r;
   logic                    comply_acknowledge_r;
   logic                    page_toggle_r;
   logic [10:0]             code_field_r;
   logic                    auto_en_r;
   logic                    force_r;
   logic [15:0]             nptx_word;
   logic [15:0]             status_word;
   logic [15:0]             control_word;
   logic [15:0]             wr_merged;
   logic                    wr_fire;
   logic                    wr_nptx;
   logic                    wr_ctrl;
   logic                    bvalid_r;
   logic [1:0]              bresp_r;
   logic                    rd_fire;
   logic                    rvalid_r;
   logic [1:0]              rresp_r;
   logic [31:0]             rdata_r;
   logic [31:0]             rd_word;

   swap_if sw ();

   assign nptx_word = {more_pages_wanted_r, 1'h0, message_page_flag_r,
                       comply_acknowledge_r, page_toggle_r, code_field_r};
   assign status_word  = {1'h0, sw.pair_swap_state, 14'h0000};
   assign control_word = {auto_en_r, force_r, 14'h0000};

   // ------------------------------------------------------------
   // Write channel
   // ------------------------------------------------------------
   // Address and data are taken together so neither can run ahead
   assign wr_fire         = axi_awvalid_in && axi_wvalid_in && !bvalid_r;
   assign axi_awready_out = wr_fire;
   assign axi_wready_out  = wr_fire;
   assign wr_nptx = wr_fire && (axi_awaddr_in == ADDR_W'(np_regs_pkg::NPTX_ADDR));
   assign wr_ctrl = wr_fire && (axi_awaddr_in == ADDR_W'(np_regs_pkg::CONTROL_ADDR));

   always_comb
   begin
      if (wr_ctrl)
         wr_merged = merge16(control_word, axi_wdata_in[15:0], axi_wstrb_in[1:0]);
      else
         wr_merged = merge16(nptx_word, axi_wdata_in[15:0], axi_wstrb_in[1:0]);
   end

   always_ff @(posedge clock_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         more_pages_wanted_r  <= np_regs_pkg::MORE_RST;
         message_page_flag_r  <= np_regs_pkg::MSG_RST;
         comply_acknowledge_r <= np_regs_pkg::ACK_RST;
         code_field_r         <= np_regs_pkg::CODE_RST;
      end
      else if (wr_nptx)
      begin
         more_pages_wanted_r  <= wr_merged[np_regs_pkg::MORE_BIT];
         message_page_flag_r  <= wr_merged[np_regs_pkg::MSG_BIT];
         comply_acknowledge_r <= wr_merged[np_regs_pkg::ACK_BIT];
         code_field_r         <= wr_merged[np_regs_pkg::CODE_W-1:0];
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
         page_toggle_r <= np_regs_pkg::TOG_RST;
      else if (page_exchanged_in)
         page_toggle_r <= !exchanged_toggle_in;
   end

   always_ff @(posedge clock_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         auto_en_r <= np_regs_pkg::AUTO_EN_RST;
         force_r   <= np_regs_pkg::FORCE_RST;
      end
      else if (wr_ctrl)
      begin
         auto_en_r <= wr_merged[np_regs_pkg::AUTO_EN_BIT];
         force_r   <= wr_merged[np_regs_pkg::FORCE_BIT];
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         bvalid_r <= 1'h0;
         bresp_r  <= np_regs_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_r <= 1'h1;
         // Status word is read only, so a write there is still OKAY
         bresp_r  <= is_mapped(axi_awaddr_in) ? np_regs_pkg::RESP_OKAY
                                              : np_regs_pkg::RESP_SLVERR;
      end
      else if (axi_bready_in)
         bvalid_r <= 1'h0;
   end

   assign axi_bvalid_out = bvalid_r;
   assign axi_bresp_out  = bresp_r;

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   assign rd_fire         = axi_arvalid_in && !rvalid_r;
   assign axi_arready_out = !rvalid_r;

   always_comb
   begin
      if (axi_araddr_in == ADDR_W'(np_regs_pkg::NPTX_ADDR))
         rd_word = {16'h0000, nptx_word};
      else if (axi_araddr_in == ADDR_W'(np_regs_pkg::STATUS_ADDR))
         rd_word = {16'h0000, status_word};
      else if (axi_araddr_in == ADDR_W'(np_regs_pkg::CONTROL_ADDR))
         rd_word = {16'h0000, control_word};
      else
         rd_word = 32'h0000_0000;
   end

   always_ff @(posedge clock_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         rvalid_r <= 1'h0;
         rresp_r  <= np_regs_pkg::RESP_OKAY;
         rdata_r  <= 32'h0000_0000;
      end
      else if (rd_fire)
      begin
         rvalid_r <= 1'h1;
         rdata_r  <= rd_word;
         rresp_r  <= is_mapped(axi_araddr_in) ? np_regs_pkg::RESP_OKAY
                                              : np_regs_pkg::RESP_SLVERR;
      end
      else if (axi_rready_in)
         rvalid_r <= 1'h0;
   end

   assign axi_rvalid_out = rvalid_r;
   assign axi_rdata_out  = rdata_r;
   assign axi_rresp_out  = rresp_r;

   // ------------------------------------------------------------
   // Negotiation and crossover
   // ------------------------------------------------------------
   // page to partner
   assign next_page_out       = nptx_word;
   assign next_page_valid_out = an_in_progress_in;

   assign sw.auto_crossover_enable = auto_en_r;
   assign sw.crossover_force       = force_r;
   assign sw.algo_swap             = pair_swap_algo_in;
   assign pair_swap_state_out      = sw.pair_swap_state;

   crossover_tracker u_tracker
   (
      .clk_in   (clock_in),
      .rst_n_in (rst_n_r),
      .sw       (sw.tracker)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_np_full_write;
      wr_nptx && (axi_wstrb_in[1:0] == 2'h3);
   endsequence

   sequence s_read_addr(logic [7:0] a);
      rd_fire && (axi_araddr_in == ADDR_W'(a));
   endsequence

   chk_reset_defaults: assert property (@(posedge clock_in)
      $rose(rst_n_r) |-> nptx_word == 16'h2001)
      else $error("next page word reset value wrong");
   chk_more_flag_write: assert property (@(posedge clock_in) disable iff (!rst_n_r)
      s_np_full_write |=> next_page_out[15] == $past(axi_wdata_in[15]))
      else $error("more pages flag not written");
   chk_reserved_np_zero: assert property (@(posedge clock_in) disable iff (!rst_n_r)
      s_read_addr(np_regs_pkg::NPTX_ADDR) |=> !axi_rdata_out[14] && axi_rvalid_out)
      else $error("reserved next page bit reads one");
   chk_msg_flag_write: assert property (@(posedge clock_in) disable iff (!rst_n_r)
      s_np_full_write |=> next_page_out[13] == $past(axi_wdata_in[13]))
      else $error("message page flag not written");
   chk_ack_flag_write: assert property (@(posedge clock_in) disable iff (!rst_n_r)
      s_np_full_write |=> next_page_out[12] == $past(axi_wdata_in[12]))
      else $error("comply acknowledge not written");
   chk_toggle_inverts: assert property (@(posedge clock_in) disable iff (!rst_n_r)
      page_exchanged_in |=> next_page_out[11] == !$past(exchanged_toggle_in))
      else $error("toggle not inverse of exchanged toggle");
   chk_code_write: assert property (@(posedge clock_in) disable iff (!rst_n_r)
      s_np_full_write |=> next_page_out[10:0] == $past(axi_wdata_in[10:0]))
      else $error("code field not written");
   chk_toggle_write_ignored: assert property (@(posedge clock_in) disable iff (!rst_n_r)
      wr_nptx && !page_exchanged_in |=> $stable(page_toggle_r))
      else $error("toggle changed by a write");
   chk_status_reserved: assert property (@(posedge clock_in) disable iff (!rst_n_r)
      s_read_addr(np_regs_pkg::STATUS_ADDR) |=> !axi_rdata_out[15])
      else $error("reserved status bit reads one");
   chk_status_swap: assert property (@(posedge clock_in) disable iff (!rst_n_r)
      s_read_addr(np_regs_pkg::STATUS_ADDR) |=> axi_rdata_out[14] == $past(pair_swap_state_out))
      else $error("status swap bit differs from tracker");
   chk_page_offered: assert property (@(posedge clock_in) disable iff (!rst_n_r)
      next_page_valid_out && $past(wr_nptx) |-> next_page_out == (($past(wr_merged) & 16'hb7ff)
         | {4'h0, page_toggle_r, 11'h000}))
      else $error("offered page differs from last write");
   chk_read_answer: assert property (@(posedge clock_in) disable iff (!rst_n_r)
      rd_fire |=> axi_rvalid_out)
      else $error("read answer missing");
   // Answer must stand until the master takes it
   chk_read_holds: assert property (@(posedge clock_in) disable iff (!rst_n_r)
      axi_rvalid_out && !axi_rready_in |=> axi_rvalid_out && $stable(axi_rdata_out))
      else $error("read answer dropped before taken");

endmodule

// ---- sim/np_partner.sv ----
// Far side model: negotiation engine exchanging pages with the link partner.
// Assumes the register block samples the exchange pulse on clock_in.
`timescale 1ns/1ps
module np_partner
(
   // Clock
   input  wire logic        clock_in,
   // Page from the device
   input  wire logic [15:0] next_page_in,
   input  wire logic        next_page_valid_in,
   // Exchange signalling
   output logic             an_in_progress_out,
   output logic             page_exchanged_out,
   output logic             exchanged_toggle_out,
   output logic [15:0]      sent_page_out
);
   initial
   begin
      an_in_progress_out   = 1'b0;
      page_exchanged_out   = 1'b0;
      exchanged_toggle_out = 1'b1;
      sent_page_out        = 16'h0000;
   end

   task automatic set_an(input logic v);
      @(posedge clock_in);
      an_in_progress_out <= v;
   endtask

   // take the device page, hand back the exchanged toggle
   // Toggle line shows the inverse outside a pulse, never a stale copy
   task automatic exchange(input logic tog, input int gap);
      @(posedge clock_in);
      page_exchanged_out   <= 1'b1;
      exchanged_toggle_out <= tog;
      if (next_page_valid_in)
         sent_page_out <= next_page_in;
      if (gap > 0)
      begin
         @(posedge clock_in);
         page_exchanged_out   <= 1'b0;
         exchanged_toggle_out <= !tog;
         repeat (gap - 1) @(posedge clock_in);
      end
   endtask
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the next page and status register block.
// Assumes AXI4-Lite answers within 50 cycles and a partner model.
`timescale 1ns/1ps
module testbench;
   logic        clock_in, reset_n_in, algo;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic        an_prog, xchg, xtog, np_valid, swap;
   logic [15:0] np_word, sent_page;
   int          miscompares, num_checks;

   next_page_regs dut_u
   (
      .clock_in(clock_in), .reset_n_in(reset_n_in),
      .axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid), .axi_awready_out(awready),
      .axi_wdata_in(wdata), .axi_wstrb_in(4'hf), .axi_wvalid_in(wvalid),
      .axi_wready_out(wready), .axi_bresp_out(bresp), .axi_bvalid_out(bvalid),
      .axi_bready_in(bready), .axi_araddr_in(araddr), .axi_arvalid_in(arvalid),
      .axi_arready_out(arready), .axi_rdata_out(rdata), .axi_rresp_out(rresp),
      .axi_rvalid_out(rvalid), .axi_rready_in(rready),
      .an_in_progress_in(an_prog), .page_exchanged_in(xchg),
      .exchanged_toggle_in(xtog), .next_page_out(np_word),
      .next_page_valid_out(np_valid), .pair_swap_algo_in(algo),
      .pair_swap_state_out(swap)
   );

   np_partner partner_u
   (
      .clock_in(clock_in), .next_page_in(np_word), .next_page_valid_in(np_valid),
      .an_in_progress_out(an_prog), .page_exchanged_out(xchg),
      .exchanged_toggle_out(xtog), .sent_page_out(sent_page)
   );

   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = !clock_in;
   end

   // ------------------------------------------------------------
   // Reporting
   // ------------------------------------------------------------
   task automatic close_out;
      $display("Checks made %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      check_val({30'h0, got}, {30'h0, exp});
   endtask

   task automatic step_limit(inout int n);
      n++;
      if (n > 50)
      begin
         miscompares++;
         close_out();
      end
   endtask

   // ------------------------------------------------------------
   // Bus master
   // ------------------------------------------------------------
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int   n;
      logic aw_d, w_d, hs_a, hs_w;
      n    = 0;
      aw_d = 1'b0;
      w_d  = 1'b0;
      @(posedge clock_in);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(aw_d && w_d))
      begin
         @(negedge clock_in);
         hs_a = awready;
         hs_w = wready;
         step_limit(n);
         @(posedge clock_in);
         if (hs_a)
            awvalid <= 1'b0;
         if (hs_w)
            wvalid <= 1'b0;
         aw_d = aw_d || hs_a;
         w_d  = w_d || hs_w;
      end
      while (!bvalid)
      begin
         step_limit(n);
         @(negedge clock_in);
      end
      r = bresp;
      @(posedge clock_in);
      bready <= 1'b0;
   endtask

   task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clock_in);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(negedge clock_in);
         step_limit(n);
      end
      while (!arready);
      @(posedge clock_in);
      arvalid <= 1'b0;
      do
      begin
         @(negedge clock_in);
         step_limit(n);
      end
      while (!rvalid);
      d = rdata;
      r = rresp;
      @(posedge clock_in);
      rready <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset_values;
      logic [31:0] d;
      logic [1:0]  r;
      bus_read(np_regs_pkg::NPTX_ADDR, d, r);
      check_val(d, 32'h0000_2001);
      check_resp(r, np_regs_pkg::RESP_OKAY);
      bus_read(np_regs_pkg::STATUS_ADDR, d, r);
      check_val(d, 32'h0000_0000);
      check_val({16'h0, np_word}, 32'h0000_2001);
   endtask

   task automatic t_fields;
      logic [31:0] d;
      logic [1:0]  r;
      bus_write(np_regs_pkg::NPTX_ADDR, 32'hffff_ffff, r);
      check_resp(r, np_regs_pkg::RESP_OKAY);
      bus_read(np_regs_pkg::NPTX_ADDR, d, r);
      check_val(d, 32'h0000_b7ff);
      partner_u.set_an(1'b1);
      @(negedge clock_in);
      check_val({31'h0, np_valid}, 32'h1);
      partner_u.exchange(1'b1, 1);
      check_val({16'h0, sent_page}, 32'h0000_b7ff);
      bus_write(np_regs_pkg::NPTX_ADDR, 32'h0000_4800, r);
      bus_read(np_regs_pkg::NPTX_ADDR, d, r);
      check_val(d, 32'h0000_0000);
   endtask

   task automatic t_toggle;
      logic [31:0] d;
      logic [1:0]  r;
      partner_u.exchange(1'b0, 1);
      @(negedge clock_in);
      check_val({31'h0, np_word[11]}, 32'h1);
      bus_write(np_regs_pkg::NPTX_ADDR, 32'h0000_0000, r);
      bus_read(np_regs_pkg::NPTX_ADDR, d, r);
      check_val(d, 32'h0000_0800);
      partner_u.exchange(1'b0, 0);
      partner_u.exchange(1'b1, 1);
      @(negedge clock_in);
      check_val({31'h0, np_word[11]}, 32'h0);
      partner_u.set_an(1'b0);
      @(negedge clock_in);
      check_val({31'h0, np_valid}, 32'h0);
   endtask

   task automatic t_crossover;
      logic [31:0] ctl [5] = '{32'h8000, 32'h8000, 32'h4000, 32'hc000, 32'h0000};
      logic        alg [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      logic        exp [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clock_in);
         algo <= alg[i];
         bus_write(np_regs_pkg::CONTROL_ADDR, ctl[i], r);
         repeat (3) @(posedge clock_in);
         bus_read(np_regs_pkg::STATUS_ADDR, d, r);
         check_val(d, {17'h0, exp[i], 14'h0});
         check_val({31'h0, swap}, {31'h0, exp[i]});
      end
      bus_read(np_regs_pkg::CONTROL_ADDR, d, r);
      check_val(d, 32'h0000_0000);
      bus_write(np_regs_pkg::STATUS_ADDR, 32'hffff_ffff, r);
      check_resp(r, np_regs_pkg::RESP_OKAY);
      bus_read(np_regs_pkg::STATUS_ADDR, d, r);
      check_val(d, 32'h0000_0000);
   endtask

   task automatic t_unmapped;
      logic [31:0] d;
      logic [1:0]  r;
      bus_write(8'h80, 32'h1234_5678, r);
      check_resp(r, np_regs_pkg::RESP_SLVERR);
      bus_read(8'h80, d, r);
      check_resp(r, np_regs_pkg::RESP_SLVERR);
      check_val(d, 32'h0000_0000);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      miscompares = 0;
      num_checks  = 0;
      reset_n_in  = 1'b0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready, algo} = '0;
      repeat (3) @(posedge clock_in);
      reset_n_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      t_reset_values();
      t_fields();
      t_toggle();
      t_crossover();
      t_unmapped();
      close_out();
   end
endmodule
